// ---- supply_clock_pkg.sv ----
// Purpose: shared constants for the supply and host clock control block
// Assumes: 32-bit Avalon-MM register port, byte addresses, 20 MHz system clock
// Notes: host clock divisors are half periods in system clock cycles
package supply_clock_pkg;
    ////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam logic [3:0] ctrl_offset = 4'h0; // control register
    localparam logic [3:0] status_offset = 4'h4; // status register
    // control register fields
    localparam int ctrl_aux_en_bit = 0; // aux converter enable
    localparam int ctrl_lin_en_bit = 1; // linear regulator enable
    localparam int ctrl_hclk_en_bit = 2; // host clock output enable
    localparam int ctrl_climit_lsb = 4; // current limit field, 3 bits
    localparam int climit_width = 3; // current limit field width
    // control register reset values
    localparam logic ctrl_aux_en_reset = 1'h1; // aux converter on by default
    localparam logic ctrl_lin_en_reset = 1'h1; // linear regulator on by default
    localparam logic ctrl_hclk_en_reset = 1'h1; // host clock on by default
    localparam logic [2:0] climit_reset = 3'h4; // binary 100
    // status register fields
    localparam int stat_supply_ok_bit = 0; // filtered supply good
    localparam int stat_aux_good_bit = 1; // aux converter output good
    localparam int stat_lin_good_bit = 2; // linear regulator output good
    localparam int stat_main_en_bit = 3; // main converter enabled
    localparam int stat_aux_en_bit = 4; // aux converter actually enabled
    localparam int stat_lin_en_bit = 5; // linear regulator actually enabled
    localparam int stat_crystal_bit = 6; // crystal chosen as clock source
    localparam int stat_mode_lsb = 8; // host clock mode, 3 bits one-hot
    localparam int stat_rate_hi_bit = 11; // strap latched high (16 MHz)
    ////////////////////////////////////////////////////////////////////////
    // clocking
    localparam int sys_clk_mhz = 20; // system clock rate
    // half periods of the host clock in system cycles; the block can only
    // approximate the nominal rates from one 20 MHz clock
    localparam int half_internal_cycles = 3; // nominal 4 MHz internal rate
    localparam int half_low_cycles = 2; // nominal 8 MHz crystal rate
    localparam int half_high_cycles = 1; // nominal 16 MHz crystal rate
    localparam int div_width = 4; // divider counter width
    ////////////////////////////////////////////////////////////////////////
    // host clock mode
    typedef enum logic [2:0] {
        hclk_off = 3'b001, // no clock, pin held low
        hclk_internal = 3'b010, // internal 4 MHz source
        hclk_crystal = 3'b100 // crystal derived 8 or 16 MHz
    } hclk_mode_t;
endpackage

// ---- supply_clock_ctrl.sv ----
// Purpose: regulator sequencing and gating plus host clock output selection
// Assumes: pins from the analog side are asynchronous, Avalon-MM slave port
// Notes: one wait state on every access; status readback is live state
//
// Behaviour
// [R1] main converter turns on after reset automatically
// [R2] host clearing aux enable keeps aux off
// [R3] aux converter enabled only with supply good
// [R4] aux output good status readable by host
// [R5] linear regulator enabled by default, host disable
// [R6] linear regulator enabled only with supply good
// [R7] linear regulator output status readable by host
// [R8] current limit field resets to 100, steps
// [R9] host clearing clock enable stops clock pin
// [R10] stand-by after power-up gives internal 4 MHz
// [R11] normal state gives 8 or 16 by strap
// [R12] non oscillator fallback keeps crystal clock
// [R13] oscillator fault fallback returns to internal clock
// [R14] source select pin picks crystal or generator
// [R15] single main clock feeds all digital logic
// [R16] host clock switches only at low phase
// [R17] aux and linear regulator enables are registered and gated
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
module supply_clock_ctrl
    import supply_clock_pkg::*;
(
    input wire logic sys_clk, // main clock, all logic runs on it R15
    input wire logic resetn, // asynchronous reset, active low
    input wire logic [3:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // write byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall until the access is taken
    input wire logic filtered_supply_ok, // pin: filtered supply above threshold
    input wire logic aux_output_good, // pin: aux converter output in range
    input wire logic linear_reg_output_good, // pin: linear regulator output good
    input wire logic normal_state, // pin: analog state machine in normal
    input wire logic osc_fault, // pin: oscillator fault reported
    input wire logic host_clock_rate_select, // strap: low 8 MHz, high 16 MHz
    input wire logic clock_source_select, // pin: high crystal, low generator
    output logic main_buck_converter_enable, // main 3.3 V converter on
    output logic aux_buck_converter_enable, // aux converter on
    output logic linear_reg_on, // linear 20 V regulator on
    output logic [2:0] linear_reg_current_limit, // current limit step field
    output logic crystal_mode, // oscillator runs as crystal driver
    output logic host_clock_out // clock towards the host
);
    ////////////////////////////////////////////////////////////////////////
    // input synchronisers, two flops each
    logic [6:0] sync_a; // first stage
    logic [6:0] sync_b; // second stage, the only reader of sync_a
    logic supply_ok_s; // synchronised filtered supply flag
    logic aux_good_s; // synchronised aux good
    logic lin_good_s; // synchronised linear good
    logic normal_s; // synchronised normal state
    logic osc_fault_s; // synchronised oscillator fault
    logic rate_hi_s; // synchronised strap
    logic src_sel_s; // synchronised source select

    // all asynchronous pins pass two flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
        end else begin
            sync_a <= {clock_source_select, host_clock_rate_select, osc_fault,
                       normal_state, linear_reg_output_good, aux_output_good,
                       filtered_supply_ok};
            sync_b <= sync_a;
        end
    end

    assign supply_ok_s = sync_b[0];
    assign aux_good_s = sync_b[1];
    assign lin_good_s = sync_b[2];
    assign normal_s = sync_b[3];
    assign osc_fault_s = sync_b[4];
    assign rate_hi_s = sync_b[5];
    assign src_sel_s = sync_b[6];

    ////////////////////////////////////////////////////////////////////////
    // control register
    logic aux_en; // host enable for aux converter
    logic lin_en; // host enable for linear regulator
    logic hclk_en; // host enable for clock output
    logic [2:0] climit; // current limit field
    logic access; // a request is present
    logic acked; // the request is answered this cycle
    logic wr_take; // write takes effect now
    logic rd_take; // read data stands now

    assign access = avs_read | avs_write;
    assign wr_take = avs_write & acked;
    assign rd_take = avs_read & acked;

    // host writes; byte lane 0 holds every control field
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            aux_en <= ctrl_aux_en_reset;
            lin_en <= ctrl_lin_en_reset; // R5
            hclk_en <= ctrl_hclk_en_reset;
            climit <= climit_reset; // R8
        end else if (wr_take && avs_address == ctrl_offset && avs_byteenable[0]) begin
            aux_en <= avs_writedata[ctrl_aux_en_bit]; // R2
            lin_en <= avs_writedata[ctrl_lin_en_bit]; // R5
            hclk_en <= avs_writedata[ctrl_hclk_en_bit]; // R9
            climit <= avs_writedata[ctrl_climit_lsb +: climit_width]; // R8
        end
    end

    // each field value is one current step from its neighbours
    assign linear_reg_current_limit = climit; // R8

    ////////////////////////////////////////////////////////////////////////
    // regulator enables, registered; aux and linear gated by the supply flag, main always on
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            main_buck_converter_enable <= 1'h0;
            aux_buck_converter_enable <= 1'h0;
            linear_reg_on <= 1'h0;
        end else begin
            main_buck_converter_enable <= 1'h1; // R1
            aux_buck_converter_enable <= aux_en & supply_ok_s; // R2 R3 R17
            linear_reg_on <= lin_en & supply_ok_s; // R6 R17
        end
    end

    // oscillator source follows the select pin level
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            crystal_mode <= 1'h0;
        end else begin
            crystal_mode <= src_sel_s; // R14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host clock mode selection
    hclk_mode_t mode; // mode now driven on the pin
    hclk_mode_t next_mode; // wanted mode
    logic rate_hi; // strap latched on entering crystal mode
    logic [div_width-1:0] div_cnt; // cycles left in the current half period
    logic boundary; // half period ends this cycle
    logic switch_now; // safe point: pin low and about to rise

    // choose the wanted mode from the analog state and the host enable
    always_comb begin
        next_mode = hclk_internal; // R10 stand-by after power-up
        if (!hclk_en) begin
            next_mode = hclk_off; // R9
        end else if (normal_s) begin
            next_mode = hclk_crystal; // R11
        end else if (mode == hclk_crystal && !osc_fault_s) begin
            next_mode = hclk_crystal; // R12
        end else if (mode == hclk_crystal) begin
            next_mode = hclk_internal; // R13
        end else if (mode == hclk_off) begin
            next_mode = hclk_internal; // R10
        end
    end

    // half period length for a mode and strap
    function automatic logic [div_width-1:0] half_len(input hclk_mode_t m, input logic hi);
        logic [div_width-1:0] len;
        len = div_width'(half_internal_cycles);
        if (m == hclk_crystal) begin
            len = hi ? div_width'(half_high_cycles) : div_width'(half_low_cycles);
        end
        return len;
    endfunction

    assign boundary = (div_cnt == '0);
    assign switch_now = boundary & ~host_clock_out;

    // mode changes only while the pin is low, at a half period boundary or on any cycle while off
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode <= hclk_internal;
            rate_hi <= 1'h0;
        end else if (switch_now || mode == hclk_off) begin
            mode <= next_mode; // R16
            if (next_mode == hclk_crystal && mode != hclk_crystal) begin
                rate_hi <= rate_hi_s; // R11
            end
        end
    end

    // divider: reloads each boundary, pin toggles unless off
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= '0;
            host_clock_out <= 1'h0;
        end else if (boundary) begin
            if (switch_now) begin
                div_cnt <= half_len(next_mode, next_mode == hclk_crystal &&
                                    mode != hclk_crystal ? rate_hi_s : rate_hi) - 1'b1;
                host_clock_out <= (next_mode != hclk_off); // R16 R9
            end else begin
                div_cnt <= half_len(mode, rate_hi) - 1'b1;
                host_clock_out <= 1'h0; // falling edge always allowed
            end
        end else begin
            div_cnt <= div_cnt - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait state, then answer
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acked <= 1'h0;
        end else begin
            acked <= access & ~acked;
        end
    end

    assign avs_waitrequest = access & ~acked;

    // read data registered on the request's first cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !acked) begin
            avs_readdata <= 32'h0000_0000; // unmapped addresses read zero
            if (avs_address == ctrl_offset) begin
                avs_readdata[ctrl_aux_en_bit] <= aux_en;
                avs_readdata[ctrl_lin_en_bit] <= lin_en;
                avs_readdata[ctrl_hclk_en_bit] <= hclk_en;
                avs_readdata[ctrl_climit_lsb +: climit_width] <= climit;
            end else if (avs_address == status_offset) begin
                avs_readdata[stat_supply_ok_bit] <= supply_ok_s;
                avs_readdata[stat_aux_good_bit] <= aux_good_s; // R4
                avs_readdata[stat_lin_good_bit] <= lin_good_s; // R7
                avs_readdata[stat_main_en_bit] <= main_buck_converter_enable;
                avs_readdata[stat_aux_en_bit] <= aux_buck_converter_enable;
                avs_readdata[stat_lin_en_bit] <= linear_reg_on;
                avs_readdata[stat_crystal_bit] <= crystal_mode;
                avs_readdata[stat_mode_lsb +: 3] <= mode;
                avs_readdata[stat_rate_hi_bit] <= rate_hi;
            end
        end
    end

    // rd_take marks the edge the master samples the data
    logic unused_rd; // read completion, kept for clarity of the handshake
    assign unused_rd = rd_take;
endmodule

// ---- supply_clock_ctrl_properties.sv ----
// Purpose: port level checks for the supply and host clock control block
// Assumes: one clock domain, asynchronous active low reset
// Notes: bound to the design from the testbench top file
`timescale 1ns/1ns
module supply_clock_ctrl_checker
    import supply_clock_pkg::*;
(
    input wire logic sys_clk, // main clock
    input wire logic resetn, // reset, active low
    input wire logic [3:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    input wire logic filtered_supply_ok, // supply good pin
    input wire logic aux_output_good, // aux good pin
    input wire logic linear_reg_output_good, // linear good pin
    input wire logic normal_state, // normal state pin
    input wire logic osc_fault, // oscillator fault pin
    input wire logic host_clock_rate_select, // rate strap
    input wire logic clock_source_select, // source select pin
    input wire logic main_buck_converter_enable, // main converter on
    input wire logic aux_buck_converter_enable, // aux converter on
    input wire logic linear_reg_on, // linear regulator on
    input wire logic [2:0] linear_reg_current_limit, // limit field
    input wire logic crystal_mode, // crystal driver
    input wire logic host_clock_out // host clock
);
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // request still stalled, and a completed read
    sequence req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    chk_main_on: assert property ($past(resetn) |-> main_buck_converter_enable)
        else $error("main converter off after reset");
    chk_reset_vals: assert property (disable iff (1'b0) !resetn |->
        linear_reg_current_limit == climit_reset && !main_buck_converter_enable)
        else $error("reset values wrong");
    chk_aux_gate: assert property (!filtered_supply_ok [*4] |-> !aux_buck_converter_enable)
        else $error("aux on without supply");
    chk_lin_gate: assert property (!filtered_supply_ok [*4] |-> !linear_reg_on)
        else $error("linear on without supply");
    chk_one_wait: assert property (req_wait |=> !avs_waitrequest)
        else $error("more than one wait state");
    chk_unmapped_zero: assert property (rd_done ##0 (avs_address != ctrl_offset &&
        avs_address != status_offset) |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_status_enables: assert property (rd_done ##0 avs_address == status_offset |->
        avs_readdata[5] == $past(linear_reg_on) && avs_readdata[4] == $past(aux_buck_converter_enable))
        else $error("status enables wrong");
    chk_source_sel: assert property ($stable(clock_source_select) [*4] |->
        crystal_mode == clock_source_select)
        else $error("crystal mode not following select");
    chk_hclk_high: assert property ($rose(host_clock_out) |-> ##[1:3] !host_clock_out)
        else $error("host clock high too long");
endmodule

// ---- analog_side_model.sv ----
// Purpose: analog side answering regulator enables with output good flags
// Assumes: output good follows an enable after a soft start of two cycles
// Notes: behavioural only
`timescale 1ns/1ns
module analog_side_model (
    input wire logic sys_clk, // main clock
    input wire logic aux_on, // aux converter enable
    input wire logic lin_on, // linear regulator enable
    output logic aux_good, // aux output in range
    output logic lin_good // linear output in range
);
    logic [1:0] aux_d = 2'h0; // aux soft start
    logic [1:0] lin_d = 2'h0; // linear soft start
    // outputs rise and fall two cycles after the enables
    always_ff @(posedge sys_clk) begin
        aux_d <= {aux_d[0], aux_on};
        lin_d <= {lin_d[0], lin_on};
    end
    assign aux_good = aux_d[1];
    assign lin_good = lin_d[1];
endmodule

// ---- tb_supply_and_host_clock_control.sv ----
// Purpose: self-checking bench for the supply and host clock control block
// Assumes: one wait state per bus access, 20 MHz clock
// Notes: reset check first, then table rows, refused accesses and host clock modes
`timescale 1ns/1ns
module tb_supply_and_host_clock_control;
    import supply_clock_pkg::*;
    logic sys_clk, resetn = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
    logic filtered_supply_ok = 1, aux_output_good, linear_reg_output_good, normal_state = 0;
    logic osc_fault = 0, host_clock_rate_select = 0, clock_source_select = 0;
    logic main_buck_converter_enable, aux_buck_converter_enable, linear_reg_on;
    logic [2:0] linear_reg_current_limit;
    logic crystal_mode, host_clock_out;
    int n_mismatch = 0, n_tests = 0, n;
    typedef struct packed {logic sup; logic cs; logic [7:0] ctrl; logic ea; logic el;} row_t;
    row_t rows[4] = '{'{1'h1, 1'h1, 8'h47, 1'h1, 1'h1}, '{1'h1, 1'h0, 8'h06, 1'h0, 1'h1},
        '{1'h1, 1'h1, 8'h75, 1'h1, 1'h0}, '{1'h0, 1'h0, 8'h47, 1'h0, 1'h0}};
    ////////////////////////////////////////////////////////////////////////
    supply_clock_ctrl uut (.*);
    analog_side_model far (.sys_clk(sys_clk), .aux_on(aux_buck_converter_enable),
        .lin_on(linear_reg_on), .aux_good(aux_output_good), .lin_good(linear_reg_output_good));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    // one access; holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    // length of one high phase of the host clock in cycles
    task automatic hi_len(input int exp, input string what);
        int k;
        k = 0;
        @(posedge sys_clk iff host_clock_out === 1'b0);
        @(posedge sys_clk iff host_clock_out === 1'b1);
        while (host_clock_out === 1'b1) begin
            k++;
            @(posedge sys_clk);
        end
        chk(what, exp, k);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #150000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        // a real falling edge, so the asynchronous reset of the design is taken
        resetn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        // the enable is launched at the first edge after release; look one edge later
        repeat (2) @(posedge sys_clk);
        chk("main enable", 1, main_buck_converter_enable);
        bus(1'b0, ctrl_offset, 32'h0000_0000);
        chk("ctrl reset", 32'h0000_0047, rd);
        chk("limit reset", climit_reset, linear_reg_current_limit);
        $display("reset test done");
        foreach (rows[i]) begin
            filtered_supply_ok <= rows[i].sup;
            clock_source_select <= rows[i].cs;
            bus(1'b1, ctrl_offset, {24'h00_0000, rows[i].ctrl});
            repeat (8) @(posedge sys_clk);
            chk("aux enable", rows[i].ea, aux_buck_converter_enable);
            chk("lin enable", rows[i].el, linear_reg_on);
            chk("limit", rows[i].ctrl[6:4], linear_reg_current_limit);
            chk("crystal", rows[i].cs, crystal_mode);
            bus(1'b0, status_offset, 32'h0000_0000);
            chk("status good", {rows[i].el, rows[i].ea, rows[i].sup}, rd[2:0]);
            $display("row %0d done", i);
        end
        filtered_supply_ok <= 1'b1;
        avs_byteenable <= 4'h0;
        bus(1'b1, ctrl_offset, 32'h0000_0000);
        avs_byteenable <= 4'hf;
        bus(1'b1, 4'h8, 32'h0000_0000);
        bus(1'b0, ctrl_offset, 32'h0000_0000);
        chk("ctrl kept", 32'h0000_0047, rd);
        bus(1'b0, 4'h8, 32'h0000_0000);
        chk("unmapped read", 32'h0000_0000, rd);
        $display("refused access test done");
        hi_len(half_internal_cycles, "internal high");
        bus(1'b0, status_offset, 32'h0000_0000);
        chk("mode internal", hclk_internal, rd[10:8]);
        normal_state <= 1'b1;
        repeat (16) @(posedge sys_clk);
        hi_len(half_low_cycles, "strap low high");
        normal_state <= 1'b0;
        repeat (16) @(posedge sys_clk);
        hi_len(half_low_cycles, "kept crystal");
        normal_state <= 1'b1;
        repeat (16) @(posedge sys_clk);
        osc_fault <= 1'b1;
        normal_state <= 1'b0;
        repeat (16) @(posedge sys_clk);
        hi_len(half_internal_cycles, "fault fallback");
        osc_fault <= 1'b0;
        host_clock_rate_select <= 1'b1;
        normal_state <= 1'b1;
        repeat (16) @(posedge sys_clk);
        hi_len(half_high_cycles, "strap high high");
        bus(1'b1, ctrl_offset, 32'h0000_0033);
        repeat (8) @(posedge sys_clk);
        n = 0;
        repeat (16) begin
            @(posedge sys_clk);
            if (host_clock_out !== 1'b0) n++;
        end
        chk("clock stopped", 0, n);
        bus(1'b0, status_offset, 32'h0000_0000);
        chk("mode off", hclk_off, rd[10:8]);
        $display("host clock test done");
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("limit in reset", climit_reset, linear_reg_current_limit);
        chk("main off in reset", 0, main_buck_converter_enable);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("main after reset", 1, main_buck_converter_enable);
        bus(1'b0, ctrl_offset, 32'h0000_0000);
        chk("ctrl after reset", 32'h0000_0047, rd);
        $display("second reset test done");
        end_sim();
    end
endmodule
bind supply_clock_ctrl supply_clock_ctrl_checker chk_i (.*);
